// file: rtl/genlock_status_pkg.sv
// Constants for the genlock phase, drift limit and reference status bank.
// Assumes word-aligned Avalon-MM byte addresses and 32-bit data.
package genlock_status_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;
  localparam int BE_W   = 4;
  localparam int IDX_W  = 6;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_SKEW     = 6'h1D;
  localparam logic [IDX_W-1:0] IDX_DRIFT    = 6'h1E;
  localparam logic [IDX_W-1:0] IDX_STATUS   = 6'h1F;
  localparam logic [IDX_W-1:0] IDX_RSV_LO   = 6'h20;
  localparam logic [IDX_W-1:0] IDX_RSV_HI   = 6'h23;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h28;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h29;

  localparam logic [REG_W-1:0] SKEW_RST  = 16'h0000;
  localparam logic [REG_W-1:0] DRIFT_RST = 16'h000B;

  // Status word fields.
  localparam int ST_VLOCK = 0;
  localparam int ST_ALOCK = 1;
  localparam int ST_BLANK = 2;
  localparam int ST_VPOL  = 3;
  localparam int ST_HPOL  = 4;
  localparam int ST_W     = 5;

  // Interrupt status and mask fields.
  localparam int EV_VLOCK_LOST = 0;
  localparam int EV_VLOCK_GAIN = 1;
  localparam int EV_ALOCK_LOST = 2;
  localparam int EV_REF_LOST   = 3;
  localparam int EV_REF_FOUND  = 4;
  localparam int EV_W          = 5;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 5'h00;

  // Positions of the synchronised detector inputs.
  localparam int IN_PRESENT = 0;
  localparam int IN_HPOL    = 1;
  localparam int IN_VPOL    = 2;
  localparam int IN_BLANK   = 3;
  localparam int IN_DIGBLK  = 4;
  localparam int IN_ALOCK   = 5;
  localparam int IN_VLOCK   = 6;
  localparam int IN_W       = 7;

endpackage

// file: rtl/genlock_phase_and_ref_status.sv
// Clock skew, reference drift limit and reference status registers.
// Assumes an Avalon-MM master on ref_clk and asynchronous detector inputs.
//
// How it works
// - Output phase shifted by clock skew count.
// - Drift limit sets lock loss, resets 000Bh.
// - Bit 4 H polarity, zero without reference.
// - Bit 3 V polarity, zero without reference.
// - Bit 3 zero for digital blanking references.
// - Bit 2 blanking timing, zero without reference.
// - Bit 1 high while audio clock locked.
// - Bit 1 always high without audio clock.
// - Bit 0 high while video clock locked.
`timescale 1ns/1ps

module genlock_phase_and_ref_status
  import genlock_status_pkg::*;
#(
  parameter int HAS_AUDIO_CLOCK = 1
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] writedata,
  input  wire logic [BE_W-1:0]   byteenable,
  output logic      [DATA_W-1:0] readdata,
  output logic                   waitrequest,
  input  wire logic              refPresentIn,
  input  wire logic              refHPolIn,
  input  wire logic              refVPolIn,
  input  wire logic              refBlankIn,
  input  wire logic              refDigitalBlankIn,
  input  wire logic              audioLockIn,
  input  wire logic              videoLockIn,
  output logic      [REG_W-1:0]  clockSkew,
  output logic      [REG_W-1:0]  driftLimit,
  output logic                   irq
);

  if (HAS_AUDIO_CLOCK != 0 && HAS_AUDIO_CLOCK != 1) begin : g_bad_param
    $error("HAS_AUDIO_CLOCK must be 0 or 1");
  end

  localparam logic [ST_W-1:0] STATUS_RST =
    (HAS_AUDIO_CLOCK != 0) ? 5'h00 : 5'h02;

  logic [IN_W-1:0]   rawIn;
  logic [IN_W-1:0]   syncA;
  logic [IN_W-1:0]   syncB;
  logic [ST_W-1:0]   statusD;
  logic [ST_W-1:0]   statusQ;
  logic              presentQ;
  logic [EV_W-1:0]   events;
  logic [EV_W-1:0]   irqStatQ;
  logic [EV_W-1:0]   irqMaskQ;
  logic [REG_W-1:0]  skewQ;
  logic [REG_W-1:0]  driftQ;
  logic [DATA_W-1:0] readMux;
  logic [DATA_W-1:0] readdataQ;
  logic              waitReqQ;
  logic              irqQ;
  logic              aligned;
  logic [IDX_W-1:0]  idx;
  logic              commit;

  assign rawIn = {videoLockIn, audioLockIn, refDigitalBlankIn, refBlankIn,
                  refVPolIn, refHPolIn, refPresentIn};

  // The detectors live in the PLL clock domains, so every level is
  // synchronised before the status logic looks at it.
  for (genvar gi = 0; gi < IN_W; gi++) begin : g_sync
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        syncA[gi] <= 1'b0;
        syncB[gi] <= 1'b0;
      end else begin
        syncA[gi] <= rawIn[gi];
        syncB[gi] <= syncA[gi];
      end
    end
  end

  always_comb begin
    statusD = '0;
    statusD[ST_HPOL]  = syncB[IN_PRESENT] & syncB[IN_HPOL];
    statusD[ST_VPOL]  = syncB[IN_PRESENT] & ~syncB[IN_DIGBLK]
                        & syncB[IN_VPOL];
    statusD[ST_BLANK] = syncB[IN_PRESENT] & syncB[IN_BLANK];
    if (HAS_AUDIO_CLOCK != 0) begin
      statusD[ST_ALOCK] = syncB[IN_ALOCK];
    end else begin
      statusD[ST_ALOCK] = 1'b1;
    end
    statusD[ST_VLOCK] = syncB[IN_VLOCK];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      statusQ  <= STATUS_RST;
      presentQ <= 1'b0;
    end else begin
      statusQ  <= statusD;
      presentQ <= syncB[IN_PRESENT];
    end
  end

  always_comb begin
    events = '0;
    events[EV_VLOCK_LOST] = statusQ[ST_VLOCK] & ~statusD[ST_VLOCK];
    events[EV_VLOCK_GAIN] = ~statusQ[ST_VLOCK] & statusD[ST_VLOCK];
    events[EV_ALOCK_LOST] = statusQ[ST_ALOCK] & ~statusD[ST_ALOCK];
    events[EV_REF_LOST]   = presentQ & ~syncB[IN_PRESENT];
    events[EV_REF_FOUND]  = ~presentQ & syncB[IN_PRESENT];
  end

  assign aligned = (address[1:0] == 2'h0);
  assign idx     = address[ADDR_W-1:2];
  // A write takes effect on the edge at which waitrequest is seen low.
  assign commit  = write & ~waitReqQ & aligned;

  function automatic logic [REG_W-1:0] merge16(
    input logic [REG_W-1:0]  old,
    input logic [DATA_W-1:0] wd,
    input logic [BE_W-1:0]   be
  );
    logic [REG_W-1:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      skewQ <= SKEW_RST;
    end else if (commit && idx == IDX_SKEW) begin
      skewQ <= merge16(skewQ, writedata, byteenable);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      driftQ <= DRIFT_RST;
    end else if (commit && idx == IDX_DRIFT) begin
      driftQ <= merge16(driftQ, writedata, byteenable);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqMaskQ <= IRQ_MASK_RST;
    end else if (commit && idx == IDX_IRQ_MASK && byteenable[0]) begin
      irqMaskQ <= writedata[EV_W-1:0];
    end
  end

  // A new event wins over a write-one clear in the same cycle.
  for (genvar ei = 0; ei < EV_W; ei++) begin : g_irq
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        irqStatQ[ei] <= 1'b0;
      end else if (events[ei]) begin
        irqStatQ[ei] <= 1'b1;
      end else if (commit && idx == IDX_IRQ_STAT && byteenable[0]
                   && writedata[ei]) begin
        irqStatQ[ei] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqQ <= 1'b0;
    end else begin
      irqQ <= |(irqStatQ & irqMaskQ);
    end
  end

  // Unused and reserved locations answer zero and drop writes.
  always_comb begin
    readMux = '0;
    if (aligned) begin
      unique case (idx)
        IDX_SKEW:     readMux[REG_W-1:0] = skewQ;
        IDX_DRIFT:    readMux[REG_W-1:0] = driftQ;
        IDX_STATUS:   readMux[ST_W-1:0]  = statusQ;
        IDX_IRQ_STAT: readMux[EV_W-1:0]  = irqStatQ;
        IDX_IRQ_MASK: readMux[EV_W-1:0]  = irqMaskQ;
        default:      readMux = '0;
      endcase
    end
  end

  // Every access costs two cycles: one with waitrequest high, one low.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitReqQ <= 1'b1;
    end else if ((read || write) && waitReqQ) begin
      waitReqQ <= 1'b0;
    end else begin
      waitReqQ <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      readdataQ <= '0;
    end else if (read && waitReqQ) begin
      readdataQ <= readMux;
    end
  end

  assign readdata    = readdataQ;
  assign waitrequest = waitReqQ;
  assign clockSkew   = skewQ;
  assign driftLimit  = driftQ;
  assign irq         = irqQ;

  property p_skew_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (commit && idx == IDX_SKEW && byteenable[1:0] == 2'h3)
      |=> clockSkew == $past(writedata[REG_W-1:0]);
  endproperty
  a_skew_write: assert property (p_skew_write)
    else $error("Clock skew did not take the written value.");

  property p_drift_write;
    @(posedge ref_clk) disable iff (!rst_n)
      (commit && idx == IDX_DRIFT && byteenable[1:0] == 2'h3)
      |=> driftLimit == $past(writedata[REG_W-1:0]);
  endproperty
  a_drift_write: assert property (p_drift_write)
    else $error("Drift limit did not take the written value.");

  property p_drift_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      !(commit && idx == IDX_DRIFT) |=> $stable(driftLimit);
  endproperty
  a_drift_hold: assert property (p_drift_hold)
    else $error("Drift limit changed without a write.");

  property p_hpol;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> statusQ[ST_HPOL]
        == $past(syncB[IN_PRESENT] & syncB[IN_HPOL]);
  endproperty
  a_hpol: assert property (p_hpol)
    else $error("H polarity status wrong.");

  property p_vpol;
    @(posedge ref_clk) disable iff (!rst_n)
      (syncB[IN_PRESENT] && !syncB[IN_DIGBLK])
      |=> statusQ[ST_VPOL] == $past(syncB[IN_VPOL]);
  endproperty
  a_vpol: assert property (p_vpol)
    else $error("V polarity status wrong.");

  property p_vpol_zero;
    @(posedge ref_clk) disable iff (!rst_n)
      (!syncB[IN_PRESENT] || syncB[IN_DIGBLK]) ##1 1'b1
      |-> !statusQ[ST_VPOL] ##1 1'b1;
  endproperty
  a_vpol_zero: assert property (p_vpol_zero)
    else $error("V polarity not zero without usable reference.");

  property p_blank;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> statusQ[ST_BLANK]
        == $past(syncB[IN_PRESENT] & syncB[IN_BLANK]);
  endproperty
  a_blank: assert property (p_blank)
    else $error("Blanking timing status wrong.");

  property p_alock;
    @(posedge ref_clk) disable iff (!rst_n)
      (HAS_AUDIO_CLOCK != 0) |=> statusQ[ST_ALOCK] == $past(syncB[IN_ALOCK]);
  endproperty
  a_alock: assert property (p_alock)
    else $error("Audio lock status does not follow the lock input.");

  property p_alock_fixed;
    @(posedge ref_clk) disable iff (!rst_n)
      (HAS_AUDIO_CLOCK == 0) |-> statusQ[ST_ALOCK];
  endproperty
  a_alock_fixed: assert property (p_alock_fixed)
    else $error("Audio lock status low without an audio clock.");

  property p_vlock;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(syncB[IN_VLOCK]) |=> statusQ[ST_VLOCK] ##1 1'b1;
  endproperty
  a_vlock: assert property (p_vlock)
    else $error("Video lock status did not rise.");

  property p_status_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (read && waitReqQ && aligned && idx == IDX_STATUS)
      |=> !waitrequest && readdata[DATA_W-1:ST_W] == '0
          && readdata[ST_W-1:0] == $past(statusQ);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("Status read returned wrong data.");

  property p_rsv_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (read && waitReqQ && aligned && idx >= IDX_RSV_LO && idx <= IDX_RSV_HI)
      |=> readdata == '0;
  endproperty
  a_rsv_read: assert property (p_rsv_read)
    else $error("Reserved address did not read zero.");

  property p_rsv_misaligned;
    @(posedge ref_clk) disable iff (!rst_n)
      (read && waitReqQ && !aligned) |=> readdata == '0;
  endproperty
  a_rsv_misaligned: assert property (p_rsv_misaligned)
    else $error("Misaligned read did not return zero.");

  property p_skew_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      !(commit && idx == IDX_SKEW) |=> $stable(clockSkew);
  endproperty
  a_skew_hold: assert property (p_skew_hold)
    else $error("Clock skew changed without a write.");

  property p_vlock_fall;
    @(posedge ref_clk) disable iff (!rst_n)
      $fell(syncB[IN_VLOCK]) |=> !statusQ[ST_VLOCK];
  endproperty
  a_vlock_fall: assert property (p_vlock_fall)
    else $error("Video lock status did not fall.");

endmodule

// file: verification/testbench.sv
// Self-checking bench for the skew, drift limit and reference status bank.
// Assumes the design package and module are compiled first; the bench is the only bus master.
`timescale 1ns/1ps

module testbench
  import genlock_status_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic              read = 1'b0;
  logic              write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [BE_W-1:0]   byteenable = '0;
  logic [IN_W-1:0]   refIn = '0;
  logic [DATA_W-1:0] readdata;
  logic [DATA_W-1:0] readdataNa;
  logic              waitrequest;
  logic [REG_W-1:0]  clockSkew;
  logic [REG_W-1:0]  driftLimit;
  logic              irq;
  logic [DATA_W-1:0] q;
  int                errors = 0;
  int                cmp_count = 0;
  logic [IN_W-1:0]   vecs [5] = '{7'h0F, 7'h1F, 7'h0E, 7'h40, 7'h20};

  always #2.5 ref_clk = ~ref_clk;

  genlock_phase_and_ref_status i_dut (
    .ref_clk          (ref_clk),
    .rst_n            (rst_n),
    .address          (address),
    .read             (read),
    .write            (write),
    .writedata        (writedata),
    .byteenable       (byteenable),
    .readdata         (readdata),
    .waitrequest      (waitrequest),
    .refPresentIn     (refIn[IN_PRESENT]),
    .refHPolIn        (refIn[IN_HPOL]),
    .refVPolIn        (refIn[IN_VPOL]),
    .refBlankIn       (refIn[IN_BLANK]),
    .refDigitalBlankIn(refIn[IN_DIGBLK]),
    .audioLockIn      (refIn[IN_ALOCK]),
    .videoLockIn      (refIn[IN_VLOCK]),
    .clockSkew        (clockSkew),
    .driftLimit       (driftLimit),
    .irq              (irq)
  );

  // A second copy without the audio clock shares every input and is read back alongside.
  genlock_phase_and_ref_status #(
    .HAS_AUDIO_CLOCK(0)
  ) i_dut_na (
    .ref_clk          (ref_clk),
    .rst_n            (rst_n),
    .address          (address),
    .read             (read),
    .write            (write),
    .writedata        (writedata),
    .byteenable       (byteenable),
    .readdata         (readdataNa),
    .waitrequest      (),
    .refPresentIn     (refIn[IN_PRESENT]),
    .refHPolIn        (refIn[IN_HPOL]),
    .refVPolIn        (refIn[IN_VPOL]),
    .refBlankIn       (refIn[IN_BLANK]),
    .refDigitalBlankIn(refIn[IN_DIGBLK]),
    .audioLockIn      (refIn[IN_ALOCK]),
    .videoLockIn      (refIn[IN_VLOCK]),
    .clockSkew        (),
    .driftLimit       (),
    .irq              ()
  );

  task automatic conclude();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One extra edge after release keeps a following request from landing in the same step.
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [BE_W-1:0] be);
    int n;
    n = 0;
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) errors++;
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    bus(1'b0, a, '0, 4'hF);
    chk(q, exp);
  endtask

  function automatic logic [DATA_W-1:0] expStatus(input logic [IN_W-1:0] v);
    logic p;
    p = v[IN_PRESENT];
    expStatus = '0;
    expStatus[ST_HPOL] = p & v[IN_HPOL];
    expStatus[ST_VPOL] = p & v[IN_VPOL] & ~v[IN_DIGBLK];
    expStatus[ST_BLANK] = p & v[IN_BLANK];
    expStatus[ST_ALOCK] = v[IN_ALOCK];
    expStatus[ST_VLOCK] = v[IN_VLOCK];
  endfunction

  task automatic t_reset();
    rdc(8'h74, 32'h00000000);
    rdc(8'h78, 32'h0000000B);
    chk({16'h0000, driftLimit}, 32'h0000000B);
  endtask

  task automatic t_skew();
    bus(1'b1, 8'h74, 32'hFFFF1234, 4'hF);
    chk({16'h0000, clockSkew}, 32'h00001234);
    rdc(8'h74, 32'h00001234);
    bus(1'b1, 8'h74, 32'h0000CDAB, 4'h1);
    rdc(8'h74, 32'h000012AB);
    bus(1'b1, 8'h74, 32'h00000000, 4'hF);
    chk({16'h0000, clockSkew}, 32'h00000000);
  endtask

  task automatic t_drift();
    bus(1'b1, 8'h78, 32'h0000ABCD, 4'hF);
    chk({16'h0000, driftLimit}, 32'h0000ABCD);
    rdc(8'h78, 32'h0000ABCD);
  endtask

  // Reset in mid-run must bring both settings back to their reset values at once.
  task automatic t_rerst();
    bus(1'b1, 8'h74, 32'h00000055, 4'hF);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({16'h0000, clockSkew}, 32'h00000000);
    chk({16'h0000, driftLimit}, 32'h0000000B);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdc(8'h78, 32'h0000000B);
  endtask

  task automatic t_resv();
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h80 + 8'(4 * i), 32'hFFFFFFFF, 4'hF);
      rdc(8'h80 + 8'(4 * i), 32'h00000000);
    end
    bus(1'b1, 8'h7C, 32'hFFFFFFFF, 4'hF);
    rdc(8'h7C, 32'h00000000);
    bus(1'b1, 8'h75, 32'h00005555, 4'hF);
    rdc(8'h74, 32'h00000000);
    rdc(8'h75, 32'h00000000);
  endtask

  task automatic t_status();
    foreach (vecs[i]) begin
      refIn <= vecs[i];
      repeat (4) @(posedge ref_clk);
      rdc(8'h7C, expStatus(vecs[i]));
      chk(readdataNa, expStatus(vecs[i]) | 32'h00000002);
    end
  endtask

  task automatic t_irq();
    refIn <= '0;
    repeat (4) @(posedge ref_clk);
    bus(1'b1, 8'hA4, 32'h00000000, 4'hF);
    bus(1'b1, 8'hA0, 32'h0000001F, 4'hF);
    refIn <= 7'h40;
    repeat (4) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h00000000);
    bus(1'b0, 8'hA0, '0, 4'hF);
    chk(q & 32'h00000002, 32'h00000002);
    bus(1'b1, 8'hA4, 32'h00000002, 4'hF);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h00000001);
    bus(1'b1, 8'hA0, 32'h00000002, 4'hF);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h00000000);
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_skew();
    t_drift();
    t_rerst();
    t_resv();
    t_status();
    t_irq();
    conclude();
  end

  // The full sequence takes under two hundred cycles, so this limit only trips on a hang.
  initial begin
    #100000;
    errors++;
    conclude();
  end
endmodule
